// File: verilog/spc_defs.vh
`ifndef SPC_DEFS_VH
`define SPC_DEFS_VH

// Register addresses on the 8-bit register port.
`define SPC_ADDR_START      8'h00
`define SPC_ADDR_CTRL       8'h01
`define SPC_ADDR_IO_EDGE    8'h02
`define SPC_ADDR_COUNTER    8'h03
`define SPC_ADDR_GEN_A      8'h04
`define SPC_ADDR_GEN_B      8'h05
`define SPC_ADDR_STATUS     8'h06
`define SPC_ADDR_IRQ_STAT   8'h08
`define SPC_ADDR_IRQ_MASK   8'h09

// Field positions.
`define SPC_START_BIT       0
`define SPC_CTRL_CLR_B      0
`define SPC_CTRL_SHARE      1
`define SPC_EDGE_A_LO       0
`define SPC_EDGE_A_HI       1
`define SPC_EDGE_B_LO       2
`define SPC_EDGE_B_HI       3
`define SPC_EDGE_A_OUT      4
`define SPC_EDGE_A_LEVEL    5
`define SPC_FLAG_A          0
`define SPC_FLAG_B          1
`define SPC_FLAG_OVF        2

// Edge select codes.
`define SPC_EDGE_NONE       2'h0
`define SPC_EDGE_RISE       2'h1
`define SPC_EDGE_FALL       2'h2
`define SPC_EDGE_BOTH       2'h3

// Reset values.
`define SPC_RST_START       1'h0
`define SPC_RST_CTRL        2'h0
`define SPC_RST_IO_EDGE     6'h00
`define SPC_RST_COUNT       16'h0000
`define SPC_RST_FLAGS       3'h0

`endif

// File: verilog/spc_pulse_capture.v
// Behaviour
// - 16-bit up-counter captured into registers A, B.
// - share bit feeds both captures from pin A.
// - sharing only while pin A is input.
// - capture B may be selected to clear counter.
// - capture A on selected rising and/or falling edge, only while pin A is input.
// - capture B on selected rising and/or falling edge.
// - start bit at 1 runs the counter.
// - capture A copies counter, sets flag A.
// - capture B copies counter, sets flag B, clears if selected.
//
// Added by the designer: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps
`include "spc_defs.vh"

module spc_pulse_capture (
  input  wire        mclk,
  input  wire        resetn,
  input  wire [7:0]  reg_addr,
  input  wire [15:0] reg_wdata,
  input  wire        reg_write,
  input  wire        reg_read,
  output reg  [15:0] reg_rdata,
  input  wire        capture_a_pin_in,
  output reg         capture_a_pin_out,
  output reg         capture_a_pin_oe,
  input  wire        capture_b_pin_in,
  output wire        irq
);

  reg         channel_start_bit;
  reg         clear_on_b;
  reg         pin_share_select;
  reg  [5:0]  io_edge_ctrl;
  reg  [15:0] channel_counter;
  reg  [15:0] general_reg_a;
  reg  [15:0] general_reg_b;
  reg  [2:0]  channel_status_reg;
  reg  [2:0]  irq_status;
  reg  [2:0]  irq_mask;

  wire [1:0]  pin_raw;
  reg  [1:0]  sync_first;
  reg  [1:0]  sync_second;
  reg  [1:0]  sync_prev;
  wire [1:0]  pin_rise;
  wire [1:0]  pin_fall;

  wire [1:0]  edge_a_sel;
  wire [1:0]  edge_b_sel;
  wire        a_is_output;
  wire        shared;
  wire        rise_b_src;
  wire        fall_b_src;
  wire        cap_a;
  wire        cap_b;
  wire        ovf;
  wire [2:0]  events;

  wire        wr_start;
  wire        wr_ctrl;
  wire        wr_edge;
  wire        wr_count;
  wire        wr_status;
  wire        wr_mask;
  wire        rd_irq_stat;
  reg  [15:0] next_rdata;

  assign pin_raw = {capture_b_pin_in, capture_a_pin_in};

  // Both pins are asynchronous to mclk, so each passes two flip-flops
  // before any edge detection looks at it.
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_pin_sync
      always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
          sync_first[gi]  <= 1'b0;
          sync_second[gi] <= 1'b0;
          sync_prev[gi]   <= 1'b0;
        end else begin
          sync_first[gi]  <= pin_raw[gi];
          sync_second[gi] <= sync_first[gi];
          sync_prev[gi]   <= sync_second[gi];
        end
      end
      assign pin_rise[gi] = sync_second[gi] & ~sync_prev[gi];
      assign pin_fall[gi] = ~sync_second[gi] & sync_prev[gi];
    end
  endgenerate

  assign edge_a_sel  = io_edge_ctrl[`SPC_EDGE_A_HI:`SPC_EDGE_A_LO];
  assign edge_b_sel  = io_edge_ctrl[`SPC_EDGE_B_HI:`SPC_EDGE_B_LO];
  assign a_is_output = io_edge_ctrl[`SPC_EDGE_A_OUT];

  assign shared = pin_share_select & ~a_is_output;

  assign rise_b_src = shared ? pin_rise[0] : pin_rise[1];
  assign fall_b_src = shared ? pin_fall[0] : pin_fall[1];

  assign cap_a = ~a_is_output &
                 ((pin_rise[0] & edge_a_sel[0]) | (pin_fall[0] & edge_a_sel[1]));

  assign cap_b = (rise_b_src & edge_b_sel[0]) | (fall_b_src & edge_b_sel[1]);

  assign ovf    = channel_start_bit & (channel_counter == 16'hffff);
  assign events = {ovf, cap_b, cap_a};

  // When pin A is an output it carries a static level that software sets.
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      capture_a_pin_out <= 1'b0;
      capture_a_pin_oe  <= 1'b0;
    end else begin
      capture_a_pin_out <= io_edge_ctrl[`SPC_EDGE_A_LEVEL];
      capture_a_pin_oe  <= a_is_output;
    end
  end

  assign wr_start    = reg_write & (reg_addr == `SPC_ADDR_START);
  assign wr_ctrl     = reg_write & (reg_addr == `SPC_ADDR_CTRL);
  assign wr_edge     = reg_write & (reg_addr == `SPC_ADDR_IO_EDGE);
  assign wr_count    = reg_write & (reg_addr == `SPC_ADDR_COUNTER);
  assign wr_status   = reg_write & (reg_addr == `SPC_ADDR_STATUS);
  assign wr_mask     = reg_write & (reg_addr == `SPC_ADDR_IRQ_MASK);
  assign rd_irq_stat = reg_read & (reg_addr == `SPC_ADDR_IRQ_STAT);

  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      channel_start_bit <= `SPC_RST_START;
      clear_on_b        <= 1'b0;
      pin_share_select  <= 1'b0;
      io_edge_ctrl      <= `SPC_RST_IO_EDGE;
      irq_mask          <= `SPC_RST_FLAGS;
    end else begin
      if (wr_start) begin
        channel_start_bit <= reg_wdata[`SPC_START_BIT];
      end
      if (wr_ctrl) begin
        clear_on_b       <= reg_wdata[`SPC_CTRL_CLR_B];
        pin_share_select <= reg_wdata[`SPC_CTRL_SHARE];
      end
      if (wr_edge) begin
        io_edge_ctrl <= reg_wdata[5:0];
      end
      if (wr_mask) begin
        irq_mask <= reg_wdata[2:0];
      end
    end
  end

  // The counter keeps counting in the cycle of a capture; the clear on
  // capture B replaces the increment, so the captured count is the period minus one cycle.
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      channel_counter <= `SPC_RST_COUNT;
    end else if (cap_b && clear_on_b) begin
      channel_counter <= `SPC_RST_COUNT;
    end else if (wr_count) begin
      channel_counter <= reg_wdata;
    end else if (channel_start_bit) begin
      channel_counter <= channel_counter + 16'h0001;
    end
  end

  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      general_reg_a <= `SPC_RST_COUNT;
      general_reg_b <= `SPC_RST_COUNT;
    end else begin
      if (cap_a) begin
        general_reg_a <= channel_counter;
      end
      if (cap_b) begin
        general_reg_b <= channel_counter;
      end
    end
  end

  // Flags clear by writing 0 to a bit; a write of 1 leaves it alone.
  // A capture in the same cycle as the clear keeps its flag set.
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      channel_status_reg <= `SPC_RST_FLAGS;
    end else begin
      channel_status_reg <= (wr_status ? (channel_status_reg & reg_wdata[2:0])
                                       : channel_status_reg) | events;
    end
  end

  // Interrupt status is cleared by its read; a new event still wins.
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      irq_status <= `SPC_RST_FLAGS;
    end else begin
      irq_status <= (rd_irq_stat ? 3'h0 : irq_status) | events;
    end
  end

  assign irq = |(irq_status & irq_mask);

  always @* begin
    next_rdata = 16'h0000;
    case (reg_addr)
      `SPC_ADDR_START:    next_rdata = {15'h0000, channel_start_bit};
      `SPC_ADDR_CTRL:     next_rdata = {14'h0000, pin_share_select, clear_on_b};
      `SPC_ADDR_IO_EDGE:  next_rdata = {10'h000, io_edge_ctrl};
      `SPC_ADDR_COUNTER:  next_rdata = channel_counter;
      `SPC_ADDR_GEN_A:    next_rdata = general_reg_a;
      `SPC_ADDR_GEN_B:    next_rdata = general_reg_b;
      `SPC_ADDR_STATUS:   next_rdata = {13'h0000, channel_status_reg};
      `SPC_ADDR_IRQ_STAT: next_rdata = {13'h0000, irq_status};
      `SPC_ADDR_IRQ_MASK: next_rdata = {13'h0000, irq_mask};
      default:            next_rdata = 16'h0000;
    endcase
  end

  // Read data stand only in the cycle after the read strobe.
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 16'h0000;
    end else if (reg_read) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

endmodule

// File: bench/spc_pulse_capture_props.sv
`timescale 1ns/10ps
module spc_props (
  input wire        mclk,
  input wire        resetn,
  input wire [7:0]  reg_addr,
  input wire [15:0] reg_wdata,
  input wire        reg_write,
  input wire        reg_read,
  input wire [15:0] reg_rdata,
  input wire        capture_a_pin_in,
  input wire        capture_a_pin_out,
  input wire        capture_a_pin_oe,
  input wire        capture_b_pin_in,
  input wire        irq
);
  reg run;
  reg mask0;
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  // Shadow of start bit and mask, kept from the writes seen on the port.
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      run <= 1'b0;
      mask0 <= 1'b1;
    end else if (reg_write) begin
      if (reg_addr == 8'h00) run <= reg_wdata[0];
      if (reg_addr == 8'h09) mask0 <= (reg_wdata == 16'h0);
    end
  end
  chk_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 16'h0) else $error("stray read data");
  chk_unmapped_zero: assert property (reg_read && reg_addr == 8'h07 |=> reg_rdata == 16'h0) else $error("unmapped read");
  chk_oe_follow: assert property (reg_write && reg_addr == 8'h02 |-> ##2 capture_a_pin_oe == $past(reg_wdata[4], 2)) else $error("pin enable");
  chk_out_follow: assert property (reg_write && reg_addr == 8'h02 |-> ##2 capture_a_pin_out == $past(reg_wdata[5], 2)) else $error("pin level");
  chk_count_step: assert property (reg_read && reg_addr == 8'h03 ##1 !reg_write ##1 reg_read && reg_addr == 8'h03 |=> reg_rdata == $past(reg_rdata, 2) + {14'h0, run, 1'b0} || reg_rdata <= 16'h2) else $error("counter step");
  chk_irq_masked: assert property (mask0 |-> !irq) else $error("masked irq");
  chk_start_back: assert property (reg_write && reg_addr == 8'h00 ##2 reg_read && reg_addr == 8'h00 |=> reg_rdata[0] == $past(reg_wdata[0], 3)) else $error("start readback");
  chk_ctrl_back: assert property (reg_write && reg_addr == 8'h01 ##2 reg_read && reg_addr == 8'h01 |=> reg_rdata[1:0] == $past(reg_wdata[1:0], 3)) else $error("ctrl readback");
  cover property (irq);
  cover property (capture_a_pin_oe);
  cover property (reg_read && reg_addr == 8'h05);
endmodule
bind spc_pulse_capture spc_props u_props (.mclk(mclk), .resetn(resetn), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .capture_a_pin_in(capture_a_pin_in), .capture_a_pin_out(capture_a_pin_out),
  .capture_a_pin_oe(capture_a_pin_oe), .capture_b_pin_in(capture_b_pin_in), .irq(irq));

// File: bench/spc_pulse_src.sv
`timescale 1ns/10ps
module spc_pulse_src (
  input  wire        mclk,
  input  wire [15:0] high_len,
  input  wire [15:0] low_len,
  output reg         pin
);
  reg [15:0] cnt = 16'h0;
  initial pin = 1'b0;
  // whole cycle levels
  // Levels change just after an edge, so rise and fall see the same sampling delay.
  always @(posedge mclk) begin
    if (cnt + 16'h1 >= (pin ? high_len : low_len)) begin
      pin <= ~pin;
      cnt <= 16'h0;
    end else begin
      cnt <= cnt + 16'h1;
    end
  end
endmodule

// File: bench/spc_pulse_capture_tb.sv
`timescale 1ns/10ps
module spc_pulse_capture_tb;
  reg         mclk;
  reg         resetn;
  reg  [7:0]  reg_addr;
  reg  [15:0] reg_wdata;
  reg         reg_write;
  reg         reg_read;
  reg         capture_b_pin_in;
  reg  [15:0] d;
  reg  [15:0] q;
  wire [15:0] reg_rdata;
  wire        pin;
  wire        pin_out;
  wire        pin_oe;
  wire        irq;
  integer     fail_count = 0;
  integer     cmp_count = 0;
  integer     cyc = 0;
  spc_pulse_src src (.mclk(mclk), .high_len(16'd20), .low_len(16'd30), .pin(pin));
  spc_pulse_capture dut (.mclk(mclk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .capture_a_pin_in(pin), .capture_a_pin_out(pin_out), .capture_a_pin_oe(pin_oe),
    .capture_b_pin_in(capture_b_pin_in), .irq(irq));
  always #5 mclk = ~mclk;
  task final_report;
    begin
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask
  always @(posedge mclk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      fail_count = fail_count + 1;
      final_report;
    end
  end
  task chk(input [15:0] s, input [15:0] e);
    begin
      cmp_count = cmp_count + 1;
      if (s !== e) begin
        fail_count = fail_count + 1;
        $display("[FAIL] %0t seen %h exp %h", $time, s, e);
      end
    end
  endtask
  task wr(input [7:0] a, input [15:0] v);
    begin
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_write <= 1'b1;
      @(posedge mclk);
      reg_write <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, output [15:0] v);
    begin
      @(posedge mclk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge mclk);
      reg_read <= 1'b0;
      #1 v = reg_rdata;
    end
  endtask
  task wait_b;
    integer n;
    begin
      d = 16'h0;
      for (n = 0; n < 100 && d[1] !== 1'b1; n++) rd(8'h06, d);
      chk({15'h0, d[1]}, 16'h1);
    end
  endtask
  task t_reset;
    integer a;
    begin
      for (a = 0; a < 10; a++) begin
        rd(a[7:0], d);
        chk(d, 16'h0);
      end
    end
  endtask
  task t_counter;
    begin
      wr(8'h01, 16'h0003);
      rd(8'h01, d);
      wr(8'h03, 16'h0100);
      rd(8'h03, d);
      chk(d, 16'h0100);
      wr(8'h00, 16'h0001);
      rd(8'h00, q);
      rd(8'h03, q);
      rd(8'h03, d);
      chk(d - q, 16'h2);
      wr(8'h00, 16'h0000);
      rd(8'h03, q);
      rd(8'h03, d);
      chk(d, q);
    end
  endtask
  task t_measure;
    begin
      wr(8'h02, 16'h0006);
      wr(8'h09, 16'h0002);
      wr(8'h00, 16'h0001);
      wait_b;
      wr(8'h06, 16'h0000);
      wait_b;
      rd(8'h04, d);
      chk(d, 16'd19);
      chk(d + 16'h1, 16'd20);
      rd(8'h05, d);
      chk(d, 16'd49);
      chk(d + 16'h1, 16'd50);
      chk({15'h0, irq}, 16'h1);
      rd(8'h08, d);
      chk({15'h0, d[1], irq}, 16'h2);
    end
  endtask
  task t_output;
    begin
      wr(8'h02, 16'h0039);
      // The pin outputs are registered behind the edge control register.
      @(posedge mclk);
      #1;
      chk({14'h0, pin_oe, pin_out}, 16'h3);
      wr(8'h06, 16'h0000);
      repeat (150) @(posedge mclk);
      rd(8'h06, d);
      chk({14'h0, d[1:0]}, 16'h0);
      rd(8'h04, d);
      chk(d, 16'd19);
      // With pin A an output, capture B must come from its own pin.
      capture_b_pin_in <= 1'b1;
      repeat (4) @(posedge mclk);
      capture_b_pin_in <= 1'b0;
      repeat (4) @(posedge mclk);
      rd(8'h06, d);
      chk({14'h0, d[1:0]}, 16'h2);
    end
  endtask
  initial begin
    mclk = 1'b0;
    resetn = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    reg_write = 1'b0;
    reg_read = 1'b0;
    capture_b_pin_in = 1'b0;
    repeat (6) @(posedge mclk);
    resetn <= 1'b1;
    t_reset;
    t_counter;
    t_measure;
    t_output;
    final_report;
  end
endmodule
